// ==== testbench/spb_host.sv ====
// host spi master model for the serial frame buffer
`timescale 1ns/1ps
module spb_host (
   input wire logic ref_clk,
   input wire logic spi_sdo,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_sdi
);
   initial begin
      spi_sclk = 1'h0;
      spi_cs_n = 1'h1;
      spi_sdi = 1'h0;
   end
   // ******************************************
   // frame shifter: 12 low + 13 high ref_clk cycles, a 125 ns period
   // ******************************************
   // sel low keeps select high, so the clock runs while not selected
   task automatic shift(input logic [127:0] data, input int nbits, input logic sel, output logic [127:0] seen);
      seen = 128'h0;
      @(negedge ref_clk);
      spi_cs_n = ~sel;
      repeat (4) @(negedge ref_clk);
      for (int i = 0; i < nbits; i++) begin
         spi_sdi = data[127 - (i % 128)];
         repeat (12) @(negedge ref_clk);
         seen = {seen[126:0], spi_sdo};
         spi_sclk = 1'h1;
         repeat (13) @(negedge ref_clk);
         spi_sclk = 1'h0;
      end
      // released data line shows the inverse so a stale value is never trusted
      spi_sdi = ~spi_sdi;
      repeat (4) @(negedge ref_clk);
      spi_cs_n = 1'h1;
      repeat (4) @(negedge ref_clk);
   endtask
endmodule

// ==== testbench/spi_channel_pattern_shift_buffer_tb_top.sv ====
// self-checking bench for the serial frame buffer
`timescale 1ns/1ps
module spi_channel_pattern_shift_buffer_tb_top;
   localparam logic [127:0] F1 = 128'h0123456789abcdeffedcba9876543210;
   localparam logic [127:0] F2 = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
   logic ref_clk = 1'h0;
   logic reset = 1'h1;
   logic spi_sclk;
   logic spi_cs_n;
   logic spi_sdi;
   logic buffer_transfer_strobe = 1'h0;
   logic power_down_input = 1'h0;
   logic spi_sdo;
   logic transfer_busy;
   logic set_valid;
   logic set_ready = 1'h0;
   logic [31:0] set_d;
   logic [31:0] set_c;
   logic [31:0] set_b;
   logic [31:0] set_a;
   logic [127:0] seen;
   int n_errors = 0;
   int checks = 0;
   always #2.5 ref_clk = ~ref_clk;
   spb_top spb_top_inst (.ref_clk(ref_clk), .reset(reset), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .buffer_transfer_strobe(buffer_transfer_strobe), .power_down_input(power_down_input),
      .spi_sdo(spi_sdo), .transfer_busy(transfer_busy), .set_valid(set_valid), .set_ready(set_ready),
      .set_d(set_d), .set_c(set_c), .set_b(set_b), .set_a(set_a));
   spb_host spb_host_inst (.ref_clk(ref_clk), .spi_sdo(spi_sdo), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi));
   // ******************************************
   // shared tasks
   // ******************************************
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic strobe;
      buffer_transfer_strobe = 1'h1;
      repeat (4) @(negedge ref_clk);
      buffer_transfer_strobe = 1'h0;
      repeat (4) @(negedge ref_clk);
   endtask
   // waits a bounded time for a frame on the sets, compares it, then takes it
   task automatic take(input logic [127:0] exp);
      int n;
      n = 0;
      while (set_valid !== 1'h1 && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      check({set_d, set_c, set_b, set_a}, exp);
      set_ready = 1'h1;
      @(negedge ref_clk);
      set_ready = 1'h0;
      @(negedge ref_clk);
   endtask
   // ******************************************
   // scenarios
   // ******************************************
   task automatic t_reset;
      check({125'h0, spi_sdo, set_valid, transfer_busy}, 128'h0);
      check({set_d, set_c, set_b, set_a}, 128'h0);
   endtask
   task automatic t_frames;
      spb_host_inst.shift(F1, 128, 1'h1, seen);
      check(seen, 128'h0);
      strobe();
      take(F1);
      spb_host_inst.shift(F2, 128, 1'h1, seen);
      check(seen, F1);
      strobe();
      take(F2);
   endtask
   task automatic t_deselect;
      // clock and data run with select high: output only previews the msb
      spb_host_inst.shift(F1, 128, 1'h0, seen);
      check(seen, {128{F2[127]}});
      strobe();
      take(F2);
   endtask
   task automatic t_power;
      power_down_input = 1'h1;
      repeat (4) @(negedge ref_clk);
      spb_host_inst.shift(F1, 128, 1'h1, seen);
      check(seen, 128'h0);
      strobe();
      repeat (30) @(negedge ref_clk);
      check({127'h0, set_valid}, 128'h0);
      power_down_input = 1'h0;
      repeat (4) @(negedge ref_clk);
      strobe();
      take(F2);
   endtask
   task automatic t_queue;
      // consumer stalls: four queued plus one shown, the sixth must wait
      repeat (6) strobe();
      check({127'h0, transfer_busy}, 128'h1);
      take(F2);
      set_ready = 1'h1;
      repeat (60) @(negedge ref_clk);
      set_ready = 1'h0;
      @(negedge ref_clk);
      check({126'h0, transfer_busy, set_valid}, 128'h0);
   endtask
   initial begin
      repeat (8) @(negedge ref_clk);
      reset = 1'h0;
      repeat (4) @(negedge ref_clk);
      t_reset();
      t_frames();
      t_deselect();
      t_power();
      t_queue();
      report_and_stop();
   end
   // four frames of about 3200 cycles each, so 200 us is ample
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule

// ==== verilog/spb_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module spb_fifo #(
   parameter int WIDTH = 128,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = (count_reg != CNT_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PTR_LAST) ? '0 : p + PTR_ONE;
   endfunction
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         if (push && !pop) begin
            count_reg <= count_reg + CNT_ONE;
         end else if (pop && !push) begin
            count_reg <= count_reg - CNT_ONE;
         end
      end
   end
endmodule

// ==== verilog/spb_pkg.sv ====
// constants shared by the serial frame buffer design
package spb_pkg;
   // ******************************************
   // frame layout
   // ******************************************
   localparam int FRAME_BITS = 128;
   localparam int SET_BITS = 32;
   localparam int SET_COUNT = 4;
   localparam int CHAN_BITS = 2;
   localparam int FRAME_MSB = FRAME_BITS - 1;
   localparam logic [1:0] SET_A = 2'h0;
   localparam logic [1:0] SET_B = 2'h1;
   localparam logic [1:0] SET_C = 2'h2;
   localparam logic [1:0] SET_D = 2'h3;
   localparam logic [FRAME_BITS-1:0] FRAME_RESET = 128'h0;
   localparam logic [SET_BITS-1:0] SET_RESET = 32'h0;
   // ******************************************
   // input synchroniser bit positions
   // ******************************************
   localparam int SYNC_BITS = 5;
   localparam int SYN_SCLK = 0;
   localparam int SYN_CS_N = 1;
   localparam int SYN_SDI = 2;
   localparam int SYN_STROBE = 3;
   localparam int SYN_PD = 4;
   // idle bus: select high, clock low, strobe low, powered up
   localparam logic [SYNC_BITS-1:0] SYNC_RESET = 5'h02;
   // ******************************************
   // buffering
   // ******************************************
   localparam int FIFO_DEPTH = 4;
   // channel n of a set sits at bits 2n+1:2n of that set
   function automatic logic [CHAN_BITS-1:0] chan_code(input logic [SET_BITS-1:0] set_word, input int n);
      chan_code = set_word[CHAN_BITS*n +: CHAN_BITS];
   endfunction
endpackage

// ==== verilog/spb_top.sv ====
// serial frame buffer: spi slave shift buffer with frame transfer queue
`timescale 1ns/1ps
module spb_top (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   input wire logic buffer_transfer_strobe,
   input wire logic power_down_input,
   output logic spi_sdo,
   output logic transfer_busy,
   output logic set_valid,
   input wire logic set_ready,
   output logic [spb_pkg::SET_BITS-1:0] set_d,
   output logic [spb_pkg::SET_BITS-1:0] set_c,
   output logic [spb_pkg::SET_BITS-1:0] set_b,
   output logic [spb_pkg::SET_BITS-1:0] set_a
);

   // ******************************************
   // declarations
   // ******************************************
   logic [spb_pkg::SYNC_BITS-1:0] sync1_reg;
   logic [spb_pkg::SYNC_BITS-1:0] sync2_reg;
   logic sclk_prev_reg;
   logic strobe_prev_reg;
   logic [spb_pkg::FRAME_BITS-1:0] serial_frame_buffer_reg;
   logic [spb_pkg::FRAME_BITS-1:0] serial_frame_buffer_next;
   logic sdo_reg;
   logic sdo_next;
   logic pending_reg;
   logic pending_next;
   logic busy_reg;
   logic set_valid_reg;
   logic set_valid_next;
   logic [spb_pkg::FRAME_BITS-1:0] frame_out_reg;
   logic [spb_pkg::FRAME_BITS-1:0] frame_out_next;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [spb_pkg::FRAME_BITS-1:0] fifo_out_data;
   logic load;

   // word of one pattern set out of a whole frame
   function automatic logic [spb_pkg::SET_BITS-1:0] set_slice(
      input logic [spb_pkg::FRAME_BITS-1:0] frame,
      input logic [1:0] set_sel
   );
      set_slice = frame[spb_pkg::SET_BITS*set_sel +: spb_pkg::SET_BITS];
   endfunction

   // ******************************************
   // input synchronisers
   // ******************************************
   // the serial clock is only sampled here, so sck must stay well below
   // a quarter of ref_clk; the host's 32 MHz ceiling leaves about six
   // samples per period
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sync1_reg <= spb_pkg::SYNC_RESET;
         sync2_reg <= spb_pkg::SYNC_RESET;
      end else begin
         sync1_reg <= {power_down_input, buffer_transfer_strobe, spi_sdi, spi_cs_n, spi_sclk};
         sync2_reg <= sync1_reg;
      end
   end

   wire sclk_s = sync2_reg[spb_pkg::SYN_SCLK];
   wire cs_n_s = sync2_reg[spb_pkg::SYN_CS_N];
   wire sdi_s = sync2_reg[spb_pkg::SYN_SDI];
   wire strobe_s = sync2_reg[spb_pkg::SYN_STROBE];
   wire pd_s = sync2_reg[spb_pkg::SYN_PD];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sclk_prev_reg <= spb_pkg::SYNC_RESET[spb_pkg::SYN_SCLK];
         strobe_prev_reg <= spb_pkg::SYNC_RESET[spb_pkg::SYN_STROBE];
      end else begin
         sclk_prev_reg <= sclk_s;
         strobe_prev_reg <= strobe_s;
      end
   end

   // ******************************************
   // edge and gating decode
   // ******************************************
   wire sclk_rise = sclk_s & ~sclk_prev_reg;
   wire sclk_fall = ~sclk_s & sclk_prev_reg;
   wire strobe_fall = ~strobe_s & strobe_prev_reg;
   // select gates clock and data, and power down shuts the port off
   wire port_active = ~cs_n_s & ~pd_s;
   wire shift_en = port_active & sclk_rise;
   wire sdo_update = port_active & sclk_fall;
   wire frame_msb = serial_frame_buffer_reg[spb_pkg::FRAME_MSB];

   // ******************************************
   // shift buffer
   // ******************************************
   // first bit in ends up at the msb after 128 rises, so set D channel 15
   // lands in the top word and set A channel 0 in the bottom bits
   // slave only: every shift is paced by the host's clock
   assign serial_frame_buffer_next = shift_en ?
      {serial_frame_buffer_reg[spb_pkg::FRAME_MSB-1:0], sdi_s} :
      serial_frame_buffer_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         serial_frame_buffer_reg <= spb_pkg::FRAME_RESET;
      end else begin
         serial_frame_buffer_reg <= serial_frame_buffer_next;
      end
   end

   // ******************************************
   // serial data out
   // ******************************************
   // while deselected and powered up the output previews the msb, so the next device in
   // the chain sees the outgoing bit before the first rising edge
   assign sdo_next = pd_s ? 1'h0 :
      (cs_n_s | sdo_update) ? frame_msb :
      sdo_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sdo_reg <= 1'h0;
      end else begin
         sdo_reg <= sdo_next;
      end
   end

   // ******************************************
   // frame transfer request
   // ******************************************
   // a strobe that meets a full queue is held pending and raises busy;
   // the buffer is copied when the queue takes it, so the host must not
   // shift a new frame while busy is high
   wire xfer_req = (strobe_fall | pending_reg) & ~pd_s;
   wire push = xfer_req & fifo_in_ready;
   assign pending_next = xfer_req & ~fifo_in_ready;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pending_reg <= 1'h0;
         busy_reg <= 1'h0;
      end else begin
         pending_reg <= pending_next;
         busy_reg <= pending_next;
      end
   end

   spb_fifo #(
      .WIDTH(spb_pkg::FRAME_BITS),
      .DEPTH(spb_pkg::FIFO_DEPTH)
   ) u_frame_fifo (
      .clk(ref_clk),
      .reset(reset),
      .in_valid(xfer_req),
      .in_ready(fifo_in_ready),
      .in_data(serial_frame_buffer_reg),
      .out_valid(fifo_out_valid),
      .out_ready(load),
      .out_data(fifo_out_data)
   );

   // ******************************************
   // pattern set output stage
   // ******************************************
   assign load = fifo_out_valid & (~set_valid_reg | set_ready);
   assign set_valid_next = load | (set_valid_reg & ~set_ready);
   assign frame_out_next = load ? fifo_out_data : frame_out_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         set_valid_reg <= 1'h0;
         frame_out_reg <= spb_pkg::FRAME_RESET;
      end else begin
         set_valid_reg <= set_valid_next;
         frame_out_reg <= frame_out_next;
      end
   end

   assign spi_sdo = sdo_reg;
   assign transfer_busy = busy_reg;
   assign set_valid = set_valid_reg;
   assign set_d = set_slice(frame_out_reg, spb_pkg::SET_D);
   assign set_c = set_slice(frame_out_reg, spb_pkg::SET_C);
   assign set_b = set_slice(frame_out_reg, spb_pkg::SET_B);
   assign set_a = set_slice(frame_out_reg, spb_pkg::SET_A);

   // ******************************************
   // assertion helpers
   // ******************************************
   // one bit is caught as it enters and followed up to the msb, so the
   // shift path is checked without copying its expression; only one bit
   // is in flight at a time, so a long stream checks every 129th bit
   localparam int TRACK_W = $clog2(spb_pkg::FRAME_BITS);
   localparam logic [TRACK_W-1:0] TRACK_LAST = TRACK_W'(spb_pkg::FRAME_MSB);
   localparam logic [TRACK_W-1:0] TRACK_ONE = TRACK_W'(1);
   logic track_on_reg;
   logic track_bit_reg;
   logic [TRACK_W-1:0] track_count_reg;
   wire track_at_msb = track_on_reg & (track_count_reg == TRACK_LAST);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         track_on_reg <= 1'h0;
         track_bit_reg <= 1'h0;
         track_count_reg <= '0;
      end else if (shift_en) begin
         track_on_reg <= ~track_at_msb;
         track_bit_reg <= track_on_reg ? track_bit_reg : sdi_s;
         track_count_reg <= track_on_reg ? track_count_reg + TRACK_ONE : '0;
      end
   end

   // ******************************************
   // assertions
   // ******************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_sample_rise: assert property (shift_en |=> serial_frame_buffer_reg[0] == $past(sdi_s))
      else $error("data in not sampled on clock rise");

   a_shift_chain: assert property (
      shift_en |=> serial_frame_buffer_reg[spb_pkg::FRAME_MSB:1] ==
         $past(serial_frame_buffer_reg[spb_pkg::FRAME_MSB-1:0]))
      else $error("buffer did not shift by one");

   a_deselect_hold: assert property (cs_n_s |=> $stable(serial_frame_buffer_reg))
      else $error("buffer changed while deselected");

   a_gate_clock: assert property (
      !(port_active && sclk_rise) |=> $stable(serial_frame_buffer_reg))
      else $error("buffer changed without a selected rising edge");

   a_out_on_fall: assert property (sdo_update |=> spi_sdo == $past(frame_msb))
      else $error("data out not updated from msb on falling edge");

   a_out_hold_rise: assert property (
      port_active && !sclk_fall ##1 port_active |-> $stable(spi_sdo))
      else $error("data out moved outside a falling edge");

   a_power_down: assert property (
      pd_s |=> !spi_sdo && $stable(serial_frame_buffer_reg))
      else $error("serial port active in power down");

   a_reset_clear: assert property (
      $past(reset) |-> serial_frame_buffer_reg == spb_pkg::FRAME_RESET && !set_valid)
      else $error("state not cleared by reset");

   a_frame_copy: assert property (
      strobe_fall && !pd_s && !pending_reg && !fifo_out_valid && !set_valid_reg
      |-> ##2 set_valid && frame_out_reg == $past(serial_frame_buffer_reg, 2))
      else $error("strobe did not deliver the held frame");

   a_set_layout: assert property (
      set_valid |-> spb_pkg::chan_code(set_d, 15) == frame_out_reg[127:126] &&
         spb_pkg::chan_code(set_a, 0) == frame_out_reg[1:0])
      else $error("pattern set layout wrong");

   a_msb_delay: assert property (track_at_msb |-> frame_msb == track_bit_reg)
      else $error("data in did not reach the msb after a full frame");

   a_tracked_out: assert property (track_at_msb && sdo_update |=> spi_sdo == $past(track_bit_reg))
      else $error("tracked bit did not leave on the falling edge");

   a_idle_buffer: assert property (!port_active |=> $stable(serial_frame_buffer_reg))
      else $error("buffer moved while the port was off");

   a_out_deselect: assert property (cs_n_s && !pd_s |=> spi_sdo == $past(frame_msb))
      else $error("deselected data out does not preview the msb");

   a_set_hold: assert property (
      set_valid && !set_ready |=> set_valid && $stable(frame_out_reg))
      else $error("pattern sets moved before they were taken");

   a_queue_feed: assert property (fifo_out_valid && !set_valid_reg |=> set_valid)
      else $error("queued frame did not reach a free output stage");

   a_busy_full: assert property (strobe_fall && !pd_s && !fifo_in_ready |=> transfer_busy)
      else $error("strobe on a full queue did not raise busy");

   a_busy_release: assert property (transfer_busy && fifo_in_ready |=> !transfer_busy)
      else $error("busy stayed high after the queue had room");

   a_pd_strobe: assert property (
      pd_s && !pending_reg && !fifo_out_valid && !set_valid_reg |-> ##2 !set_valid)
      else $error("strobe acted during power down");

   a_reset_outputs: assert property (
      $past(reset) |-> frame_out_reg == spb_pkg::FRAME_RESET && !transfer_busy && !spi_sdo)
      else $error("outputs not cleared by reset");

   c_shift: cover property (shift_en ##1 sdo_update);
   c_transfer: cover property (push ##2 set_valid);
   c_stall: cover property (set_valid && !set_ready ##1 set_valid);
   c_busy: cover property (pending_reg && strobe_fall);
   c_power_down: cover property (pd_s && strobe_fall);

endmodule
